// >>> dv/i2cm_assertions.sv
// Purpose: port checker for the bus master
// Assumes: core clock domain ports only
// Notes: bound to the controller at the foot
`timescale 1ns/100ps
module i2cm_assertions
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic [i2cm_pkg::LVL_W-1:0] txLevel,
	input wire logic rxValid,
	input wire logic [i2cm_pkg::LVL_W-1:0] rxLevel,
	input wire logic ownAddrLoad,
	input wire logic [9:0] ownAddrIn,
	input wire logic [9:0] ownAddr,
	input wire logic [i2cm_pkg::N_EV-1:0] intrSet,
	input wire logic [i2cm_pkg::N_EV-1:0] intrMask,
	input wire logic [i2cm_pkg::N_EV-1:0] intrRaw,
	input wire logic [i2cm_pkg::N_EV-1:0] intrFlags,
	input wire logic dmaTxReq,
	input wire logic dmaRxReq,
	input wire logic busActive
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////////////
	// a push into an idle queue must open a transfer; bound covers slow rate
	sequence s_push;
		txValid && txReady && !busActive && txLevel == i2cm_pkg::FIFO_EMPTY;
	endsequence
	sequence s_busy;
		##[1:400] busActive;
	endsequence
	property p_start; s_push |-> s_busy; endproperty
	a_start: assert property (p_start) else $error("no start after push");
	property p_own; $rose(reset_n) |-> ownAddr == i2cm_pkg::OWN_ADDR_RST; endproperty
	a_own: assert property (p_own) else $error("own address reset");
	property p_load; ownAddrLoad |=> ownAddr == $past(ownAddrIn); endproperty
	a_load: assert property (p_load) else $error("own address load");
	property p_txrdy; txReady == (txLevel != i2cm_pkg::FIFO_FULL); endproperty
	a_txrdy: assert property (p_txrdy) else $error("tx ready vs level");
	property p_rxv; rxValid == (rxLevel != i2cm_pkg::FIFO_EMPTY); endproperty
	a_rxv: assert property (p_rxv) else $error("rx valid vs level");
	property p_dma; dmaTxReq == txReady && dmaRxReq == rxValid; endproperty
	a_dma: assert property (p_dma) else $error("dma request");
	property p_flag; 1'b1 |=> intrFlags == (intrRaw & $past(intrMask)); endproperty
	a_flag: assert property (p_flag) else $error("masked flags");
	property p_set; intrSet != 0 |=> (intrRaw & $past(intrSet)) == $past(intrSet); endproperty
	a_set: assert property (p_set) else $error("raw set");
endmodule
bind i2cm_ctrl i2cm_assertions i2cm_assertions_i (.core_clk, .reset_n, .txValid, .txReady,
	.txLevel, .rxValid, .rxLevel, .ownAddrLoad, .ownAddrIn, .ownAddr, .intrSet, .intrMask,
	.intrRaw, .intrFlags, .dmaTxReq, .dmaRxReq, .busActive);

// >>> dv/i2cm_slave.sv
// Purpose: behavioural 7-bit slave on the wired bus
// Assumes: lines pulled up outside
// Notes: stretch makes it hold the clock low
`timescale 1ns/100ps
module i2cm_slave
#(
	parameter logic [6:0] ADDR = 7'h3a
)
(
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] rdData,
	input wire integer stretch,
	output logic sdaPull,
	output logic sclPull,
	output logic [7:0] firstByte,
	output logic [7:0] lastByte
);
	logic [7:0] sh;
	int bitN;
	logic act = 1'b0;
	logic rd;
	logic adr;
	initial sdaPull = 1'b0;
	initial sclPull = 1'b0;
	// start and restart alike arm the address phase
	always @(negedge sda)
		if (scl)
		begin
			act = 1'b1;
			adr = 1'b1;
			bitN = 0;
		end
	always @(posedge sda)
		if (scl)
			act = 1'b0;
	// sample on rise; a nack from the master ends the read
	always @(posedge scl)
		if (act)
		begin
			if (bitN < 8)
				sh = {sh[6:0], sda};
			else if (rd && sda)
				act = 1'b0;
			bitN = (bitN == 8) ? 0 : bitN + 1;
		end
	// drive well after the fall so the master sees no hold hazard
	always @(negedge scl)
	begin
		#20;
		if (act && bitN == 8 && adr)
		begin
			firstByte = sh;
			rd = sh[0];
			adr = 1'b0;
			act = (sh[7:1] == ADDR);
			sdaPull = act;
		end
		else if (act && bitN == 8)
		begin
			lastByte = sh;
			sdaPull = !rd;
		end
		else
			sdaPull = act && rd && !adr && !rdData[7 - bitN];
	end
	// clock held low to pause the master
	always @(negedge scl)
		if (act && stretch > 0)
		begin
			sclPull = 1'b1;
			#(stretch);
			sclPull = 1'b0;
		end
endmodule

// >>> dv/i2cm_tb.sv
// Purpose: self-checking bench for the bus master
// Assumes: one slave on the wired bus
// Notes: each scenario is a task
`timescale 1ns/100ps
module tb;
	localparam logic [6:0] SLV = 7'h3a;
	localparam logic [7:0] RDB = 8'hc6;
	logic core_clk, reset_n, linkClk, txValid, rxReady, ownAddrLoad, sclOe, sdaOe, txReady;
	logic rxValid, busActive, slvSda, slvScl;
	wire logic scl = !(sclOe | slvScl);
	wire logic sda = !(sdaOe | slvSda);
	i2cm_pkg::i2cm_entry_t txEntry;
	i2cm_pkg::i2cm_rx_t rxEntry;
	i2cm_pkg::i2cm_cfg_t cfg;
	logic [9:0] ownAddrIn, ownAddr;
	logic [i2cm_pkg::LVL_W-1:0] txLevel;
	logic [3:0] intrSet, intrClear, intrMask, intrRaw, intrFlags;
	logic [7:0] firstByte, lastByte;
	int stretch, miscompares, checksDone;
	i2cm_ctrl i2cm_ctrl_i (.core_clk, .reset_n, .linkClk, .sclIn(scl), .sclOut(), .sclOe,
		.sdaIn(sda), .sdaOut(), .sdaOe, .txValid, .txEntry, .txReady, .rxValid, .rxEntry,
		.rxReady, .txLevel, .rxLevel(), .cfg, .ownAddrLoad, .ownAddrIn, .ownAddr, .intrSet,
		.intrClear, .intrMask, .intrRaw, .intrFlags, .dmaTxReq(), .dmaRxReq(), .busActive);
	i2cm_slave #(.ADDR(SLV)) i2cm_slave_i (.scl, .sda, .rdData(RDB), .stretch,
		.sdaPull(slvSda), .sclPull(slvScl), .firstByte, .lastByte);
	initial begin core_clk = 0; forever #50 core_clk = !core_clk; end
	initial begin linkClk = 0; #7; forever #15 linkClk = !linkClk; end
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(); @(posedge core_clk); #10; endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// bounded wait for a whole transfer, start to stop
	task automatic waitBus();
		int n;
		n = 0;
		while (busActive !== 1'b1 && n++ < 3000) tick();
		if (n > 3000) n = 9000;
		while (busActive !== 1'b0 && n++ < 9000) tick();
		chk(16'(n >= 9000), 16'h0);
		tick(); // event flags lag busy by one cycle
	endtask
	task automatic setup(input logic [i2cm_pkg::CNT_W+12:0] c);
		cfg = c;
		intrClear = 4'hf;
		tick();
		intrClear = 4'h0;
	endtask
	task automatic tIntr();
		intrMask = 4'h2; intrSet = 4'h3; tick(); intrSet = 4'h0; tick();
		chk(intrRaw, 4'h3);
		chk(intrFlags, 4'h2);
		ownAddrLoad = 1'b1; ownAddrIn = 10'h1c3; tick(); ownAddrLoad = 1'b0; tick();
		chk(ownAddr, 10'h1c3);
	endtask
	// two writes back to back; stretch pauses the bit engine
	task automatic tWrite(input logic fast, input int s);
		stretch = s;
		setup({1'b0, 1'b0, fast, 8'h05, 3'h0, SLV});
		txValid = 1'b1; txEntry = {1'b0, 8'h5e}; tick();
		chk(txLevel, 3'h1);
		// data differs per rate so a stale byte cannot pass
		txEntry = {1'b0, 8'ha7 + fast}; tick(); txValid = 1'b0;
		waitBus();
		chk(firstByte, {SLV, 1'b0});
		chk(lastByte, 8'ha7 + fast);
		chk(intrRaw[1:0], 2'h3);
		stretch = 0;
	endtask
	// write, repeated start, two reads: first acked, last nacked
	task automatic tRead();
		setup({1'b1, 1'b0, 1'b1, 8'h03, 3'h0, SLV});
		txValid = 1'b1; txEntry = {1'b0, 8'h5e}; tick();
		txEntry = {1'b1, 8'h00}; tick(); tick(); txValid = 1'b0;
		waitBus();
		chk(firstByte, {SLV, 1'b1});
		// a stop before the reads would end the wait with nothing received
		chk({rxValid, rxEntry}, {2'h3, RDB});
		rxReady = 1'b1; tick();
		chk({rxValid, rxEntry}, {2'h2, RDB});
		tick(); rxReady = 1'b0;
		chk(rxValid, 1'b0);
	endtask
	// no slave answers the long address: nack abort
	task automatic tTen();
		setup({1'b0, 1'b1, 1'b1, 8'h05, 10'h2a5});
		txValid = 1'b1; txEntry = {1'b0, 8'h11}; tick(); txValid = 1'b0;
		waitBus();
		chk(firstByte, {i2cm_pkg::TEN_BIT_PREFIX, 3'h4});
		chk(intrRaw[3], 1'b1);
	endtask
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		{reset_n, txValid, rxReady, ownAddrLoad, ownAddrIn, txEntry, cfg} = '0;
		{intrSet, intrClear, intrMask, stretch, miscompares, checksDone} = '0;
		repeat (3) @(posedge core_clk);
		#10 reset_n = 1'b1;
		chk({ownAddr, txReady, rxValid, txLevel}, {i2cm_pkg::OWN_ADDR_RST, 5'h10});
		tIntr();
		tWrite(1'b0, 0);
		tWrite(1'b1, 3000);
		tRead();
		tTen();
		wrapUp();
	end
	// watchdog well past the longest expected run
	initial
	begin
		#4000000;
		miscompares++;
		wrapUp();
	end
endmodule

// >>> rtl/i2cm_ctrl.sv
// Purpose: two-wire bus master with 4-deep queues and a link-clock bit engine
// Assumes: sclIn/sdaIn are the wired bus levels; linkClk runs free
// Notes: queue entries cross to the link domain by a toggle handshake
// Notes on behaviour
// - start: data falls while clock high, busy
// - stop: data rises while clock high, free
// - repeated start keeps the bus busy
// - repeated start made like a plain start
// - master starts, clocks and stops each transfer
// - address and direction bit follow start
// - receiver of a byte drives its acknowledge
// - write bytes continue until stop
// - reader acks all but last, nacks last
// - separate 4x9 transmit and receive queues, levels
// - standard and fast rates up to 400 kb/s
// - 7-bit and 10-bit addressing, combined transfers
// - own slave address resets to 0x055
// - data hold after clock fall is programmable
// - wait while a slave holds clock low
// - monitor sees start, stop; bit engine sees lost arbitration
// - domain crossings use toggles and synchronizers
// - raw and masked interrupt flags, set/clear
// - configurable only as bus master
// - queued entry starts, empty queue stops
// - 7-bit byte: address 7:1, direction bit 0
// - 10-bit: prefix, bits 9:8, direction; then 7:0
// - direction change restarts only when enabled
`timescale 1ns/100ps
module i2cm_ctrl
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic linkClk,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic txValid,
	input wire i2cm_pkg::i2cm_entry_t txEntry,
	output logic txReady,
	output logic rxValid,
	output i2cm_pkg::i2cm_rx_t rxEntry,
	input wire logic rxReady,
	output logic [i2cm_pkg::LVL_W-1:0] txLevel,
	output logic [i2cm_pkg::LVL_W-1:0] rxLevel,
	input wire i2cm_pkg::i2cm_cfg_t cfg,
	input wire logic ownAddrLoad,
	input wire logic [9:0] ownAddrIn,
	output logic [9:0] ownAddr,
	input wire logic [i2cm_pkg::N_EV-1:0] intrSet,
	input wire logic [i2cm_pkg::N_EV-1:0] intrClear,
	input wire logic [i2cm_pkg::N_EV-1:0] intrMask,
	output logic [i2cm_pkg::N_EV-1:0] intrRaw,
	output logic [i2cm_pkg::N_EV-1:0] intrFlags,
	output logic dmaTxReq,
	output logic dmaRxReq,
	output logic busActive
);
	////////////////////////////////////////////////////////////////////////////////
	// core domain declarations
	i2cm_pkg::i2cm_entry_t txMem_reg [i2cm_pkg::FIFO_DEPTH];
	i2cm_pkg::i2cm_rx_t rxMem_reg [i2cm_pkg::FIFO_DEPTH];
	logic [i2cm_pkg::PTR_W-1:0] txWr_reg, txRd_reg, rxWr_reg, rxRd_reg;
	logic [i2cm_pkg::LVL_W-1:0] txLvl_reg, rxLvl_reg;
	logic reqS1_reg, reqS2_reg, reqDone_reg, respTgl_reg;
	i2cm_pkg::i2cm_resp_t respPay_reg;
	logic [i2cm_pkg::N_EV-1:0] evS1_reg, evS2_reg, evS3_reg, intrRaw_reg, intrFlags_reg;
	logic [i2cm_pkg::N_EV-1:0] evPulse, intrRaw_next;
	logic busyS1_reg, busyS2_reg;
	logic [9:0] ownAddr_reg;
	logic txPush, txPop, rxPush, rxPop, answer;

	////////////////////////////////////////////////////////////////////////////////
	// link domain declarations
	logic rstS1_reg, linkRstN;
	logic sclS1_reg, sclS2_reg, sdaS1_reg, sdaS2_reg, sdaPrev_reg, busy_reg;
	logic [1:0] monTgl_reg, fsmTgl_reg;
	logic respS1_reg, respS2_reg, respDone_reg, reqTgl_reg, respPend;
	i2cm_pkg::i2cm_req_t reqPay_reg;
	i2cm_pkg::i2cm_state_t state_reg;
	i2cm_pkg::i2cm_phase_t phase_reg;
	i2cm_pkg::i2cm_after_t after_reg;
	i2cm_pkg::i2cm_cfg_t cfg_reg;
	i2cm_pkg::i2cm_entry_t entry_reg;
	logic [i2cm_pkg::CNT_W-1:0] cnt_reg, halfLast, qtrLast, holdAt;
	logic [3:0] bitCnt_reg;
	logic [8:0] shift_reg;
	logic [7:0] rxShift_reg, addrByte;
	logic sclOe_reg, sdaOe_reg, owned_reg, pendValid_reg, readNow_reg;
	logic first_reg, goStop_reg, nack_reg;

	////////////////////////////////////////////////////////////////////////////////
	// core: queues and user handshakes
	assign txReady = txLvl_reg != i2cm_pkg::FIFO_FULL;
	assign txPush = txValid & txReady;
	assign rxValid = rxLvl_reg != i2cm_pkg::FIFO_EMPTY;
	assign rxPop = rxValid & rxReady;
	assign rxEntry = rxMem_reg[rxRd_reg];
	assign txLevel = txLvl_reg;
	assign rxLevel = rxLvl_reg;
	assign dmaTxReq = txReady;
	assign dmaRxReq = rxValid;
	// a read byte waits in the link domain while the receive queue is full
	assign answer = (reqS2_reg != reqDone_reg)
		& (~reqPay_reg.rxValid | (rxLvl_reg != i2cm_pkg::FIFO_FULL));
	assign txPop = answer & (txLvl_reg != i2cm_pkg::FIFO_EMPTY);
	assign rxPush = answer & reqPay_reg.rxValid;

	// transmit queue
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			txWr_reg <= '0;
			txRd_reg <= '0;
			txLvl_reg <= i2cm_pkg::FIFO_EMPTY;
		end
		else
		begin
			if (txPush)
			begin
				txMem_reg[txWr_reg] <= txEntry;
				txWr_reg <= txWr_reg + 1'b1;
			end
			if (txPop)
				txRd_reg <= txRd_reg + 1'b1;
			txLvl_reg <= txLvl_reg + {2'h0, txPush} - {2'h0, txPop};
		end
	end

	// receive queue
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			rxWr_reg <= '0;
			rxRd_reg <= '0;
			rxLvl_reg <= i2cm_pkg::FIFO_EMPTY;
		end
		else
		begin
			if (rxPush)
			begin
				rxMem_reg[rxWr_reg] <= reqPay_reg.rx;
				rxWr_reg <= rxWr_reg + 1'b1;
			end
			if (rxPop)
				rxRd_reg <= rxRd_reg + 1'b1;
			rxLvl_reg <= rxLvl_reg + {2'h0, rxPush} - {2'h0, rxPop};
		end
	end

	// core end of the request/response toggle handshake
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			reqS1_reg <= 1'b0;
			reqS2_reg <= 1'b0;
			reqDone_reg <= 1'b0;
			respTgl_reg <= 1'b0;
			respPay_reg <= '0;
		end
		else
		begin
			reqS1_reg <= reqTgl_reg;
			reqS2_reg <= reqS1_reg;
			if (answer)
			begin
				reqDone_reg <= reqS2_reg;
				respTgl_reg <= ~respTgl_reg;
				respPay_reg <= '{valid: txLvl_reg != i2cm_pkg::FIFO_EMPTY,
					entry: txMem_reg[txRd_reg], cfg: cfg};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// core: event crossing, interrupt flags, own address
	assign evPulse = evS2_reg ^ evS3_reg;
	// set wins over clear so an event in the clearing cycle survives
	assign intrRaw_next = (intrRaw_reg & ~intrClear) | evPulse | intrSet;
	assign intrRaw = intrRaw_reg;
	assign intrFlags = intrFlags_reg;
	assign busActive = busyS2_reg;
	assign ownAddr = ownAddr_reg;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			evS1_reg <= '0;
			evS2_reg <= '0;
			evS3_reg <= '0;
			busyS1_reg <= 1'b0;
			busyS2_reg <= 1'b0;
			intrRaw_reg <= '0;
			intrFlags_reg <= '0;
		end
		else
		begin
			evS1_reg <= {fsmTgl_reg, monTgl_reg};
			evS2_reg <= evS1_reg;
			evS3_reg <= evS2_reg;
			busyS1_reg <= busy_reg;
			busyS2_reg <= busyS1_reg;
			intrRaw_reg <= intrRaw_next;
			intrFlags_reg <= intrRaw_next & intrMask;
		end
	end

	// own address is only reported; the block never answers as a slave
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			ownAddr_reg <= i2cm_pkg::OWN_ADDR_RST;
		else if (ownAddrLoad)
			ownAddr_reg <= ownAddrIn;
	end

	////////////////////////////////////////////////////////////////////////////////
	// link: reset, pin synchronizers and bus monitor
	always_ff @(posedge linkClk)
	begin
		rstS1_reg <= reset_n;
		linkRstN <= rstS1_reg;
	end

	always_ff @(posedge linkClk)
	begin
		if (!linkRstN)
		begin
			sclS1_reg <= 1'b1;
			sclS2_reg <= 1'b1;
			sdaS1_reg <= 1'b1;
			sdaS2_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			busy_reg <= 1'b0;
			monTgl_reg <= '0;
		end
		else
		begin
			sclS1_reg <= sclIn;
			sclS2_reg <= sclS1_reg;
			sdaS1_reg <= sdaIn;
			sdaS2_reg <= sdaS1_reg;
			sdaPrev_reg <= sdaS2_reg;
			// a repeated start leaves busy set; only a stop frees the bus
			if (sclS2_reg && sdaPrev_reg && !sdaS2_reg)
			begin
				busy_reg <= 1'b1;
				monTgl_reg[i2cm_pkg::EV_START] <= ~monTgl_reg[i2cm_pkg::EV_START];
			end
			else if (sclS2_reg && !sdaPrev_reg && sdaS2_reg)
			begin
				busy_reg <= 1'b0;
				monTgl_reg[i2cm_pkg::EV_STOP] <= ~monTgl_reg[i2cm_pkg::EV_STOP];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// link: timing and address byte
	assign halfLast = cfg_reg.fastMode ? i2cm_pkg::FAST_HALF_LAST : i2cm_pkg::STD_HALF_LAST;
	assign qtrLast = cfg_reg.fastMode ? i2cm_pkg::FAST_QTR_LAST : i2cm_pkg::STD_QTR_LAST;
	// hold is clamped so data still settles a quarter bit before clock rises
	assign holdAt = (cfg_reg.sdaHold < qtrLast) ? cfg_reg.sdaHold : qtrLast;
	assign respPend = respS2_reg != respDone_reg;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = sclOe_reg;
	assign sdaOe = sdaOe_reg;

	always_comb
	begin
		unique case (phase_reg)
			i2cm_pkg::PH_ADDR1:
				addrByte = cfg_reg.tenBit
					? {i2cm_pkg::TEN_BIT_PREFIX, cfg_reg.targetAddr[9:8], 1'b0}
					: {cfg_reg.targetAddr[6:0], entry_reg.rd};
			i2cm_pkg::PH_ADDR2:
				addrByte = cfg_reg.targetAddr[7:0];
			i2cm_pkg::PH_ADDR1R:
				addrByte = {i2cm_pkg::TEN_BIT_PREFIX, cfg_reg.targetAddr[9:8], 1'b1};
			i2cm_pkg::PH_DATA:
				addrByte = entry_reg.data;
		endcase
	end

	always_ff @(posedge linkClk)
	begin
		if (!linkRstN)
		begin
			respS1_reg <= 1'b0;
			respS2_reg <= 1'b0;
		end
		else
		begin
			respS1_reg <= respTgl_reg;
			respS2_reg <= respS1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// link: master bit engine
	always_ff @(posedge linkClk)
	begin
		if (!linkRstN)
		begin
			state_reg <= i2cm_pkg::ST_IDLE;
			phase_reg <= i2cm_pkg::PH_ADDR1;
			after_reg <= i2cm_pkg::AF_STOP;
			cfg_reg <= '0;
			entry_reg <= '0;
			cnt_reg <= '0;
			bitCnt_reg <= '0;
			shift_reg <= '1;
			rxShift_reg <= '0;
			sclOe_reg <= 1'b0;
			sdaOe_reg <= 1'b0;
			owned_reg <= 1'b0;
			pendValid_reg <= 1'b0;
			readNow_reg <= 1'b0;
			first_reg <= 1'b0;
			goStop_reg <= 1'b0;
			nack_reg <= 1'b0;
			reqTgl_reg <= 1'b0;
			reqPay_reg <= '0;
			respDone_reg <= 1'b0;
			fsmTgl_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				// poll the transmit queue while not owning the bus
				i2cm_pkg::ST_IDLE:
				begin
					sclOe_reg <= 1'b0;
					sdaOe_reg <= 1'b0;
					reqTgl_reg <= ~reqTgl_reg;
					reqPay_reg <= '0;
					state_reg <= i2cm_pkg::ST_WAIT;
				end
				// with the bus owned, clock is held low here while the core answers; entered from ST_IDLE it stays released
				i2cm_pkg::ST_WAIT:
				begin
					if (respPend)
					begin
						respDone_reg <= respS2_reg;
						cfg_reg <= respPay_reg.cfg;
						cnt_reg <= '0;
						if (respPay_reg.valid)
						begin
							entry_reg <= respPay_reg.entry;
							pendValid_reg <= 1'b1;
						end
						if (!owned_reg)
						begin
							phase_reg <= i2cm_pkg::PH_ADDR1;
							state_reg <= respPay_reg.valid ? i2cm_pkg::ST_START1
								: i2cm_pkg::ST_IDLE;
						end
						else if (readNow_reg)
						begin
							bitCnt_reg <= i2cm_pkg::BIT_ACK;
							state_reg <= i2cm_pkg::ST_LOW;
							if (respPay_reg.valid && respPay_reg.entry.rd)
							begin
								shift_reg <= {1'b0, 8'hff};
								after_reg <= i2cm_pkg::AF_READ;
							end
							else
							begin
								shift_reg <= '1;
								after_reg <= (respPay_reg.valid && respPay_reg.cfg.restartEn)
									? i2cm_pkg::AF_RESTART : i2cm_pkg::AF_STOP;
							end
						end
						else if (!respPay_reg.valid)
						begin
							goStop_reg <= 1'b1;
							state_reg <= i2cm_pkg::ST_PRE;
						end
						else if (respPay_reg.entry.rd)
						begin
							goStop_reg <= ~respPay_reg.cfg.restartEn;
							phase_reg <= i2cm_pkg::PH_ADDR1;
							state_reg <= i2cm_pkg::ST_PRE;
						end
						else
						begin
							shift_reg <= {respPay_reg.entry.data, 1'b1};
							phase_reg <= i2cm_pkg::PH_DATA;
							bitCnt_reg <= '0;
							state_reg <= i2cm_pkg::ST_LOW;
						end
					end
				end
				// wait for a free, idle bus, then pull data low under high clock
				i2cm_pkg::ST_START1:
				begin
					sclOe_reg <= 1'b0;
					sdaOe_reg <= 1'b0;
					cnt_reg <= (!busy_reg && sclS2_reg && sdaS2_reg) ? cnt_reg + 1'b1 : '0;
					if (!busy_reg && sclS2_reg && sdaS2_reg && cnt_reg == halfLast)
					begin
						sdaOe_reg <= 1'b1;
						owned_reg <= 1'b1;
						cnt_reg <= '0;
						state_reg <= i2cm_pkg::ST_START2;
					end
				end
				// shared by start and repeated start
				i2cm_pkg::ST_START2:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == halfLast)
					begin
						sclOe_reg <= 1'b1;
						cnt_reg <= '0;
						bitCnt_reg <= '0;
						readNow_reg <= 1'b0;
						shift_reg <= {addrByte, 1'b1};
						state_reg <= i2cm_pkg::ST_LOW;
					end
				end
				i2cm_pkg::ST_LOW:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == holdAt)
						sdaOe_reg <= ~shift_reg[8];
					if (cnt_reg == halfLast)
					begin
						sclOe_reg <= 1'b0;
						cnt_reg <= '0;
						state_reg <= i2cm_pkg::ST_HIGH;
					end
				end
				i2cm_pkg::ST_HIGH:
				begin
					// a slave holding clock low freezes the bit
					if (sclS2_reg)
					begin
						cnt_reg <= cnt_reg + 1'b1;
						if (cnt_reg == qtrLast)
						begin
							rxShift_reg <= {rxShift_reg[6:0], sdaS2_reg};
							nack_reg <= sdaS2_reg;
							if (!sdaOe_reg && !sdaS2_reg && !readNow_reg
								&& bitCnt_reg != i2cm_pkg::BIT_ACK)
							begin
								fsmTgl_reg[0] <= ~fsmTgl_reg[0];
								owned_reg <= 1'b0;
								pendValid_reg <= 1'b0;
								sclOe_reg <= 1'b0;
								sdaOe_reg <= 1'b0;
								state_reg <= i2cm_pkg::ST_IDLE;
							end
						end
						if (cnt_reg == halfLast)
						begin
							sclOe_reg <= 1'b1;
							cnt_reg <= '0;
							shift_reg <= {shift_reg[7:0], 1'b1};
							if (readNow_reg && bitCnt_reg == i2cm_pkg::BIT_DATA_LAST)
							begin
								reqTgl_reg <= ~reqTgl_reg;
								reqPay_reg <= '{rxValid: 1'b1,
									rx: '{first: first_reg, data: rxShift_reg}};
								first_reg <= 1'b0;
								pendValid_reg <= 1'b0;
								state_reg <= i2cm_pkg::ST_WAIT;
							end
							else if (bitCnt_reg != i2cm_pkg::BIT_ACK)
							begin
								bitCnt_reg <= bitCnt_reg + 1'b1;
								state_reg <= i2cm_pkg::ST_LOW;
							end
							else if (readNow_reg)
							begin
								unique case (after_reg)
									i2cm_pkg::AF_READ:
									begin
										shift_reg <= '1;
										bitCnt_reg <= '0;
										state_reg <= i2cm_pkg::ST_LOW;
									end
									i2cm_pkg::AF_RESTART:
									begin
										readNow_reg <= 1'b0;
										goStop_reg <= 1'b0;
										phase_reg <= i2cm_pkg::PH_ADDR1;
										state_reg <= i2cm_pkg::ST_PRE;
									end
									i2cm_pkg::AF_STOP:
									begin
										readNow_reg <= 1'b0;
										goStop_reg <= 1'b1;
										state_reg <= i2cm_pkg::ST_PRE;
									end
								endcase
							end
							else if (nack_reg)
							begin
								// no acknowledge: drop the entry and stop
								fsmTgl_reg[1] <= ~fsmTgl_reg[1];
								pendValid_reg <= 1'b0;
								goStop_reg <= 1'b1;
								state_reg <= i2cm_pkg::ST_PRE;
							end
							else
							begin
								unique case (phase_reg)
									i2cm_pkg::PH_ADDR1:
									begin
										bitCnt_reg <= '0;
										state_reg <= i2cm_pkg::ST_LOW;
										if (cfg_reg.tenBit)
										begin
											shift_reg <= {cfg_reg.targetAddr[7:0], 1'b1};
											phase_reg <= i2cm_pkg::PH_ADDR2;
										end
										else if (entry_reg.rd)
										begin
											shift_reg <= '1;
											readNow_reg <= 1'b1;
											first_reg <= 1'b1;
										end
										else
										begin
											shift_reg <= {entry_reg.data, 1'b1};
											phase_reg <= i2cm_pkg::PH_DATA;
										end
									end
									i2cm_pkg::PH_ADDR2:
									begin
										if (entry_reg.rd)
										begin
											// 10-bit read turns round with a repeated start
											phase_reg <= i2cm_pkg::PH_ADDR1R;
											goStop_reg <= 1'b0;
											state_reg <= i2cm_pkg::ST_PRE;
										end
										else
										begin
											shift_reg <= {entry_reg.data, 1'b1};
											phase_reg <= i2cm_pkg::PH_DATA;
											bitCnt_reg <= '0;
											state_reg <= i2cm_pkg::ST_LOW;
										end
									end
									i2cm_pkg::PH_ADDR1R:
									begin
										shift_reg <= '1;
										readNow_reg <= 1'b1;
										first_reg <= 1'b1;
										bitCnt_reg <= '0;
										state_reg <= i2cm_pkg::ST_LOW;
									end
									i2cm_pkg::PH_DATA:
									begin
										pendValid_reg <= 1'b0;
										reqTgl_reg <= ~reqTgl_reg;
										reqPay_reg <= '0;
										state_reg <= i2cm_pkg::ST_WAIT;
									end
								endcase
							end
						end
					end
				end
				// clock low: set data low for a stop, high for a repeated start
				i2cm_pkg::ST_PRE:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == holdAt)
						sdaOe_reg <= goStop_reg;
					if (cnt_reg == halfLast)
					begin
						sclOe_reg <= 1'b0;
						cnt_reg <= '0;
						state_reg <= i2cm_pkg::ST_RISE;
					end
				end
				i2cm_pkg::ST_RISE:
				begin
					if (sclS2_reg)
					begin
						cnt_reg <= cnt_reg + 1'b1;
						if (cnt_reg == halfLast)
						begin
							cnt_reg <= '0;
							sdaOe_reg <= ~goStop_reg;
							owned_reg <= ~goStop_reg;
							state_reg <= goStop_reg ? i2cm_pkg::ST_FREE : i2cm_pkg::ST_START2;
						end
					end
				end
				// bus free time, then a pending entry opens a new transfer
				i2cm_pkg::ST_FREE:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == halfLast)
					begin
						cnt_reg <= '0;
						phase_reg <= i2cm_pkg::PH_ADDR1;
						state_reg <= pendValid_reg ? i2cm_pkg::ST_START1 : i2cm_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// >>> rtl/i2cm_pkg.sv
// Purpose: shared constants and types for the two-wire bus master controller
// Assumes: core clock 10 MHz, link clock about 33 MHz (30 ns)
// Notes: bit timing counts are derived from the link clock period
package i2cm_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// clocks and bus timing
	localparam int CORE_CLK_NS = 100;
	localparam int LINK_CLK_NS = 30;
	localparam int STD_BIT_NS = 10000; // standard rate, 100 kb/s
	localparam int FAST_BIT_NS = 2500; // fast rate, 400 kb/s
	localparam int CNT_W = 8;
	// least times, so round up to whole link cycles
	localparam logic [CNT_W-1:0] STD_HALF_LAST =
		CNT_W'((STD_BIT_NS / 2 + LINK_CLK_NS - 1) / LINK_CLK_NS - 1);
	localparam logic [CNT_W-1:0] STD_QTR_LAST =
		CNT_W'((STD_BIT_NS / 4 + LINK_CLK_NS - 1) / LINK_CLK_NS - 1);
	localparam logic [CNT_W-1:0] FAST_HALF_LAST =
		CNT_W'((FAST_BIT_NS / 2 + LINK_CLK_NS - 1) / LINK_CLK_NS - 1);
	localparam logic [CNT_W-1:0] FAST_QTR_LAST =
		CNT_W'((FAST_BIT_NS / 4 + LINK_CLK_NS - 1) / LINK_CLK_NS - 1);

	////////////////////////////////////////////////////////////////////////////////
	// queues, addresses, bit positions
	localparam int FIFO_DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int LVL_W = 3;
	localparam logic [LVL_W-1:0] FIFO_FULL = 3'h4;
	localparam logic [LVL_W-1:0] FIFO_EMPTY = 3'h0;
	localparam logic [9:0] OWN_ADDR_RST = 10'h055;
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
	localparam logic [3:0] BIT_DATA_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam int N_EV = 4;
	localparam int EV_START = 0;
	localparam int EV_STOP = 1;
	localparam int EV_ARB = 2;
	localparam int EV_ABORT = 3;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic rd;
		logic [7:0] data;
	} i2cm_entry_t;
	typedef struct packed {
		logic first;
		logic [7:0] data;
	} i2cm_rx_t;
	typedef struct packed {
		logic restartEn;
		logic tenBit;
		logic fastMode;
		logic [7:0] sdaHold;
		logic [9:0] targetAddr;
	} i2cm_cfg_t;
	typedef struct packed {
		logic valid;
		i2cm_entry_t entry;
		i2cm_cfg_t cfg;
	} i2cm_resp_t;
	typedef struct packed {
		logic rxValid;
		i2cm_rx_t rx;
	} i2cm_req_t;

	typedef enum logic [3:0] {ST_IDLE, ST_WAIT, ST_START1, ST_START2, ST_LOW, ST_HIGH,
		ST_PRE, ST_RISE, ST_FREE} i2cm_state_t;
	typedef enum logic [1:0] {PH_ADDR1, PH_ADDR2, PH_ADDR1R, PH_DATA} i2cm_phase_t;
	typedef enum logic [1:0] {AF_READ, AF_RESTART, AF_STOP} i2cm_after_t;
endpackage
